// ===== hw/scs_clk_mux.sv
// scs_clk_mux: glitch-free two-source selector for the sampled slow clock.
// assumes: both sources already synchronised to clk_sys; target may change any time.
`timescale 1ns/1ps
module scs_clk_mux
  import scs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rc_src,
  input wire logic xtal_src,
  input wire logic target_sel,
  output logic slow_clk,
  output logic cur_sel,
  output logic busy,
  output logic drained
);

  scs_mux_state_t state_reg;
  scs_mux_state_t state_next;
  logic cur_sel_reg;
  logic cur_sel_next;
  logic slow_clk_reg;
  logic new_src_reg;
  wire logic cur_src;
  wire logic new_src;
  wire logic pass_out;

  assign cur_src = cur_sel_reg ? xtal_src : rc_src;
  assign new_src = target_sel ? xtal_src : rc_src;
  // old clock finishes its high phase before the gate closes
  assign pass_out = (state_reg == SCS_RUN) || (state_reg == SCS_DRAIN);

  always_comb begin
    state_next = state_reg;
    cur_sel_next = cur_sel_reg;
    case (state_reg)
      SCS_RUN: begin
        if (target_sel != cur_sel_reg) begin
          state_next = SCS_DRAIN;
        end
      end
      SCS_DRAIN: begin
        if (!cur_src) begin
          state_next = SCS_WAIT;
        end
      end
      SCS_WAIT: begin
        // hand over just after a falling edge of the new source, so neither phase runs short;
        // limitation: a dead new source holds the switch until it toggles
        if (!new_src && new_src_reg) begin
          cur_sel_next = target_sel;
          state_next = SCS_RUN;
        end
      end
      default: begin
        state_next = SCS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= SCS_RUN;
      cur_sel_reg <= 1'b0;
      slow_clk_reg <= 1'b0;
      new_src_reg <= 1'b0;
    end else begin
      new_src_reg <= new_src;
      state_reg <= state_next;
      cur_sel_reg <= cur_sel_next;
      slow_clk_reg <= pass_out & cur_src;
    end
  end

  assign slow_clk = slow_clk_reg;
  assign cur_sel = cur_sel_reg;
  assign busy = (state_reg != SCS_RUN);
  assign drained = (state_reg == SCS_WAIT);

endmodule : scs_clk_mux

// ===== hw/scs_defs.svh
// scs_defs.svh: offsets, field positions, reset values and counts for the
// slow clock source select block.
// assumes: included by bare name from each design file that needs it.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

`define SCS_ADDR_W 4
`define SCS_DATA_W 32
`define SCS_CFG_W 4

// byte addresses on the register bus
`define SCS_CFG_OFFSET 4'h0
`define SCS_STAT_OFFSET 4'h4

// slow_clock_config fields
`define SCS_CFG_RC_EN_BIT 0
`define SCS_CFG_XTAL_EN_BIT 1
`define SCS_CFG_BYPASS_BIT 2
`define SCS_CFG_SELECT_BIT 3
`define SCS_CFG_RESET 4'h1

// slow_clock_status fields
`define SCS_STAT_CUR_SEL_BIT 0
`define SCS_STAT_BUSY_BIT 1
`define SCS_STAT_DRAINED_BIT 2

// resynchronisation window that software waits, in slow clock cycles, then synchroniser depth in flip-flops
`define SCS_RESYNC_SLOW_CYCLES 5
`define SCS_SYNC_STAGES 2

`endif

// ===== hw/scs_pkg.sv
// scs_pkg: types shared by the slow clock source select design.
// assumes: nothing beyond the tool's own library.
package scs_pkg;

  // order along the switch path: run -> drain -> wait -> run; one bit changes per step except wait -> run
  typedef enum logic [1:0] {
    SCS_RUN = 2'b00,
    SCS_DRAIN = 2'b01,
    SCS_WAIT = 2'b11
  } scs_mux_state_t;

  typedef enum logic {
    SCS_SRC_RC = 1'b0,
    SCS_SRC_XTAL = 1'b1
  } scs_src_t;

endpackage : scs_pkg

// ===== hw/scs_sync.sv
// scs_sync: two flip-flop level synchroniser, one per bit.
// assumes: inputs are asynchronous to clk_sys; only the last stage is read.
`timescale 1ns/1ps
module scs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : scs_sync

// ===== hw/scs_top.sv
// scs_top: slow clock source select with its configuration register.
// assumes: Avalon-MM master on clk_sys; resetn is the backup-supply power-on
// reset, so the register keeps its contents while that supply stays up.
// Functional notes
// - the enable, bypass and select bits live in the backup domain and survive while its supply stays present.
// - the RC oscillator runs while its enable bit is 1 and the crystal oscillator while its enable bit is 1.
// - the slow clock comes from the crystal when select is 1 and from the RC oscillator when it is 0.
// - with bypass set the crystal path takes an external clock from the crystal input pin.
// - after backup power-on reset the RC enable is 1, crystal enable 0 and select 0.
// - the block never sequences a switch on its own; only software writes change the bits.
// - changing select never produces a glitch on the slow clock output; a bypass change with the crystal selected switches at once.
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_top
  import scs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [`SCS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`SCS_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [`SCS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rc_osc_clk,
  input wire logic xtal_osc_clk,
  input wire logic xtal_input_pin,
  output logic rc_osc_enable,
  output logic xtal_osc_enable,
  output logic xtal_bypass,
  output logic slow_clk
);

  // register bus
  logic ack_reg;
  logic [`SCS_DATA_W-1:0] readdata_reg;
  logic [`SCS_DATA_W-1:0] readdata_next;
  logic [`SCS_CFG_W-1:0] cfg_reg;
  logic [`SCS_CFG_W-1:0] cfg_next;
  wire logic req;
  wire logic accept;
  wire logic hit_cfg;
  wire logic hit_stat;
  wire logic wr_cfg;
  wire logic [`SCS_DATA_W-1:0] stat_word;
  wire logic [`SCS_DATA_W-1:0] cfg_word;
  wire logic [`SCS_DATA_W-1:0] rd_mux;

  // clock path
  wire logic [2:0] pins_async;
  wire logic [2:0] pins_sync;
  wire logic rc_s;
  wire logic xtal_s;
  wire logic pin_s;
  wire logic rc_src;
  wire logic xtal_src;
  wire logic mux_cur_sel;
  wire logic mux_busy;
  wire logic mux_drained;
  wire logic mux_run;

  function automatic logic [`SCS_DATA_W-1:0] scs_zext(input logic [`SCS_CFG_W-1:0] v);
    scs_zext = {{(`SCS_DATA_W-`SCS_CFG_W){1'b0}}, v};
  endfunction : scs_zext

  // one wait cycle per access: request seen, then answered
  assign req = avs_read | avs_write;
  assign accept = req & ack_reg;
  assign avs_waitrequest = req & ~ack_reg;
  assign hit_cfg = (avs_address == `SCS_CFG_OFFSET);
  assign hit_stat = (avs_address == `SCS_STAT_OFFSET);
  // only byte lane 0 holds bits; other lanes are ignored
  assign wr_cfg = accept & avs_write & hit_cfg & avs_byteenable[0];

  assign cfg_word = scs_zext(cfg_reg);
  assign stat_word = scs_zext({1'b0, mux_drained, mux_busy, mux_cur_sel});
  // unmapped addresses read as zero and ignore writes
  assign rd_mux = hit_cfg ? cfg_word : (hit_stat ? stat_word : '0);

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg) begin
      cfg_next = avs_writedata[`SCS_CFG_W-1:0];
    end
  end

  always_comb begin
    readdata_next = readdata_reg;
    if (avs_read && !ack_reg) begin
      readdata_next = rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      readdata_reg <= '0;
    end else begin
      ack_reg <= req & ~ack_reg;
      readdata_reg <= readdata_next;
    end
  end

  // backup-domain bits: loaded with SCS_CFG_RESET only by the backup power-on reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_reg <= `SCS_CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign avs_readdata = readdata_reg;

  // oscillator controls come straight from the stored bits
  assign rc_osc_enable = cfg_reg[`SCS_CFG_RC_EN_BIT];
  assign xtal_osc_enable = cfg_reg[`SCS_CFG_XTAL_EN_BIT];
  assign xtal_bypass = cfg_reg[`SCS_CFG_BYPASS_BIT];

  assign pins_async = {xtal_input_pin, xtal_osc_clk, rc_osc_clk};

  scs_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign rc_s = pins_sync[0];
  assign xtal_s = pins_sync[1];
  assign pin_s = pins_sync[2];

  // a disabled oscillator contributes a steady low
  assign rc_src = rc_s & cfg_reg[`SCS_CFG_RC_EN_BIT];
  // bypass takes the pin even with the crystal amplifier disabled
  assign xtal_src = cfg_reg[`SCS_CFG_BYPASS_BIT] ? pin_s : (xtal_s & cfg_reg[`SCS_CFG_XTAL_EN_BIT]);

  scs_clk_mux u_mux (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rc_src(rc_src),
    .xtal_src(xtal_src),
    .target_sel(cfg_reg[`SCS_CFG_SELECT_BIT]),
    .slow_clk(slow_clk),
    .cur_sel(mux_cur_sel),
    .busy(mux_busy),
    .drained(mux_drained)
  );

  assign mux_run = ~mux_busy;

  // ---- assertions

  property p_reset_default;
    @(posedge clk_sys) disable iff (!resetn)
    $past(!resetn) |-> (cfg_reg == `SCS_CFG_RESET) && rc_osc_enable && !xtal_osc_enable && !slow_clk;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("config not at default after reset");

  property p_bits_hold;
    @(posedge clk_sys) disable iff (!resetn)
    !wr_cfg |=> $stable(cfg_reg);
  endproperty
  a_bits_hold: assert property (p_bits_hold) else $error("config changed without a write");

  property p_readback;
    @(posedge clk_sys) disable iff (!resetn)
    (avs_read && !avs_waitrequest && hit_cfg) |-> avs_readdata == scs_zext(cfg_reg);
  endproperty
  a_readback: assert property (p_readback) else $error("config readback differs from stored bits");

  property p_rc_enable;
    @(posedge clk_sys) disable iff (!resetn)
    wr_cfg |=> rc_osc_enable == $past(avs_writedata[`SCS_CFG_RC_EN_BIT]);
  endproperty
  a_rc_enable: assert property (p_rc_enable) else $error("rc enable does not follow write");

  property p_xtal_enable;
    @(posedge clk_sys) disable iff (!resetn)
    wr_cfg |=> xtal_osc_enable == $past(avs_writedata[`SCS_CFG_XTAL_EN_BIT]);
  endproperty
  a_xtal_enable: assert property (p_xtal_enable) else $error("crystal enable does not follow write");

  property p_bypass_path;
    @(posedge clk_sys) disable iff (!resetn)
    (mux_run && mux_cur_sel && xtal_bypass) |=> slow_clk == $past(pin_s);
  endproperty
  a_bypass_path: assert property (p_bypass_path) else $error("bypass clock not passed to output");

  property p_select_follows;
    @(posedge clk_sys) disable iff (!resetn)
    (mux_run && !mux_cur_sel) |=> slow_clk == $past(rc_src);
  endproperty
  a_select_follows: assert property (p_select_follows) else $error("rc source not passed to output");

  property p_switch_starts;
    @(posedge clk_sys) disable iff (!resetn)
    (mux_run && (mux_cur_sel != cfg_reg[`SCS_CFG_SELECT_BIT])) |=> mux_busy;
  endproperty
  a_switch_starts: assert property (p_switch_starts) else $error("select change not picked up");

  property p_gap_low;
    @(posedge clk_sys) disable iff (!resetn)
    mux_drained |=> !slow_clk;
  endproperty
  a_gap_low: assert property (p_gap_low) else $error("output not held low during handover");

  property p_no_cut_high;
    @(posedge clk_sys) disable iff (!resetn)
    (mux_run && $past(mux_run) && $fell(slow_clk)) |-> !$past(mux_cur_sel ? xtal_src : rc_src);
  endproperty
  a_no_cut_high: assert property (p_no_cut_high) else $error("high phase cut short");

  property p_bus_answer;
    @(posedge clk_sys) disable iff (!resetn)
    req |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered in one wait cycle");

  property p_write_takes;
    @(posedge clk_sys) disable iff (!resetn)
    wr_cfg |=> cfg_reg == $past(avs_writedata[`SCS_CFG_W-1:0]);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("config write not stored");

  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (!resetn)
    (avs_read && !avs_waitrequest && !hit_cfg && !hit_stat) |-> avs_readdata == '0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_status_upper;
    @(posedge clk_sys) disable iff (!resetn)
    (avs_read && !avs_waitrequest && hit_stat) |-> avs_readdata[`SCS_DATA_W-1:3] == '0;
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits not zero");

  c_to_xtal: cover property (@(posedge clk_sys) disable iff (!resetn) mux_busy ##1 (mux_run && mux_cur_sel));
  c_to_rc: cover property (@(posedge clk_sys) disable iff (!resetn) mux_busy ##1 (mux_run && !mux_cur_sel));
  c_bypass: cover property (@(posedge clk_sys) disable iff (!resetn) mux_run && mux_cur_sel && xtal_bypass && slow_clk);
  c_read_stat: cover property (@(posedge clk_sys) disable iff (!resetn) avs_read && !avs_waitrequest && hit_stat);

endmodule : scs_top

// ===== verification/scs_top_test.sv
// scs_top_test: self-checking bench for the slow clock source select block.
// assumes: scs_top on clk_sys, Avalon-MM master and oscillators driven here.
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_top_test;
  import scs_pkg::*;
  localparam int RC_HALF = 10;
  localparam int XT_HALF = 13;
  localparam int EX_HALF = 11;
  localparam int TIMEOUT = 40000;
  logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest;
  logic [`SCS_ADDR_W-1:0] avs_address;
  logic [`SCS_DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, cfg, be, ha, hb, hc;
  logic rc_osc_clk, xtal_osc_clk, xtal_input_pin, rc_osc_enable, xtal_osc_enable, xtal_bypass, slow_clk, last;
  int bad_count, checked, cycles, rcc, xtc, exc, mode, run, min_run, took;
  bit run_ok;

  scs_top scs_top_i (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rc_osc_clk(rc_osc_clk),
    .xtal_osc_clk(xtal_osc_clk), .xtal_input_pin(xtal_input_pin), .rc_osc_enable(rc_osc_enable),
    .xtal_osc_enable(xtal_osc_enable), .xtal_bypass(xtal_bypass), .slow_clk(slow_clk));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  // free-running sources with unequal periods, so a bad handover shows as a short pulse
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      bad_count++;
      end_of_test();
    end
    rcc <= (rcc == RC_HALF - 1) ? 0 : rcc + 1;
    xtc <= (xtc == XT_HALF - 1) ? 0 : xtc + 1;
    exc <= (exc == EX_HALF - 1) ? 0 : exc + 1;
    if (rcc == RC_HALF - 1) rc_osc_clk <= ~rc_osc_clk;
    if (xtc == XT_HALF - 1) xtal_osc_clk <= ~xtal_osc_clk;
    if (exc == EX_HALF - 1) xtal_input_pin <= ~xtal_input_pin;
  end

  // slow_clk must repeat the chosen source three cycles late
  always @(negedge clk_sys) begin
    ha = {ha[2:0], rc_osc_clk};
    hb = {hb[2:0], xtal_osc_clk};
    hc = {hc[2:0], xtal_input_pin};
    if (resetn && mode != 0) check_bit("slow_clk", (mode == 1) ? ha[3] : (mode == 2) ? hb[3] : hc[3], slow_clk);
    if (slow_clk !== last) begin
      if (run_ok && run < min_run) min_run = run;
      run_ok = 1'b1;
      run = 1;
    end else run++;
    last = slow_clk;
  end

  // request held until waitrequest is seen low at a rising edge; only the bench timeout ends a wait
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_byteenable <= 4'hf;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_read

  // status polling bounds the handover time; gate pulse width tracked meanwhile
  task automatic switch_to(input logic [31:0] d, input logic want);
    mode = 0;
    run_ok = 1'b0;
    min_run = 1000;
    bus_write(`SCS_CFG_OFFSET, d, 4'hf);
    took = cycles;
    rd = {31'h0, ~want};
    for (int i = 0; i < 100 && rd[0] !== want; i++) bus_read(`SCS_STAT_OFFSET, rd);
    check_bit("handover in window", 1'b1, (cycles - took) <= 5 * 2 * XT_HALF);
    check_bit("current source", want, rd[0]);
    // full resync window before the old oscillator may be turned off
    repeat (5 * 2 * XT_HALF) @(posedge clk_sys);
    check_bit("no glitch", 1'b1, min_run >= RC_HALF - 1);
  endtask : switch_to

  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {rc_osc_clk, xtal_osc_clk, xtal_input_pin, resetn, last, run_ok} = '0;
    {bad_count, checked, cycles, rcc, xtc, exc, mode, run} = '0;
    {ha, hb, hc} = '0;
    min_run = 1000;
    void'($urandom(32'hcfa7_fc01));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check_word("reset outputs", 32'h0000_0001, {xtal_bypass, xtal_osc_enable, rc_osc_enable});
    bus_read(`SCS_CFG_OFFSET, rd);
    check_word("config reset", 32'h0000_0001, rd);
    bus_read(`SCS_STAT_OFFSET, rd);
    check_word("status reset", 32'h0000_0000, rd);
    cfg = 4'h1;
    for (int i = 0; i < 16; i++) begin
      rd = $urandom;
      be = 4'($urandom_range(15, 0));
      rd[3] = 1'b0;
      if (be[0]) cfg = rd[3:0];
      bus_write(`SCS_CFG_OFFSET, rd, be);
      bus_write(4'({$urandom_range(3, 2), 2'b00}), $urandom, 4'hf);
      bus_write(`SCS_STAT_OFFSET, $urandom, 4'hf);
      bus_read(`SCS_CFG_OFFSET, rd);
      check_word("config readback", {28'h0, cfg}, rd);
      check_word("enable pins", {29'h0, cfg[2:0]}, {xtal_bypass, xtal_osc_enable, rc_osc_enable});
      bus_read(4'({$urandom_range(3, 2), 2'b00}), rd);
      check_word("unmapped read", 32'h0000_0000, rd);
    end
    bus_write(`SCS_CFG_OFFSET, 32'h0000_0001, 4'hf);
    mode = 1;
    bus_write(`SCS_CFG_OFFSET, 32'h0000_0003, 4'hf);
    repeat (60) @(posedge clk_sys);
    switch_to(32'h0000_000b, 1'b1);
    mode = 2;
    bus_write(`SCS_CFG_OFFSET, 32'h0000_000a, 4'hf);
    repeat (80) @(posedge clk_sys);
    check_bit("rc disabled", 1'b0, rc_osc_enable);
    mode = 0;
    bus_write(`SCS_CFG_OFFSET, 32'h0000_000e, 4'hf);
    repeat (8) @(posedge clk_sys);
    mode = 3;
    bus_write(`SCS_CFG_OFFSET, 32'h0000_000c, 4'hf);
    repeat (80) @(posedge clk_sys);
    check_bit("bypass pin", 1'b1, xtal_bypass);
    bus_write(`SCS_CFG_OFFSET, 32'h0000_000d, 4'hf);
    repeat (60) @(posedge clk_sys);
    switch_to(32'h0000_0005, 1'b0);
    mode = 1;
    bus_write(`SCS_CFG_OFFSET, 32'h0000_0001, 4'hf);
    repeat (80) @(posedge clk_sys);
    bus_read(`SCS_STAT_OFFSET, rd);
    check_word("status idle", 32'h0000_0000, rd);
    end_of_test();
  end
endmodule : scs_top_test
